// file: hdl/ep_cfg_regs.svh
`ifndef EP_CFG_REGS_SVH
`define EP_CFG_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_DEV_IDENT    8'h00
`define OFS_ASM_IDENT    8'h08
`define OFS_ASM_INFO     8'h0C
`define OFS_PE_FEAT      8'h10
`define OFS_SER_BASE     8'h14
`define OFS_LANE_BASE    8'h18
`define OFS_USER_BASE    8'h1C
`define OFS_LINK_TO      8'h20
`define OFS_RESP_TO      8'h24
`define OFS_GEN_CTRL     8'h28
`define OFS_STATUS       8'h2C

// ----------------------------------------
// field positions
// ----------------------------------------
`define PE_BRIDGE_BIT    31
`define PE_MEMORY_BIT    30
`define PE_PROC_BIT      29
`define GC_HOST_BIT      31
`define GC_MEN_BIT       30
`define GC_DISC_BIT      29
`define TO_VAL_LSB       8
`define ST_EXPIRED_BIT   0
`define ST_RUNNING_BIT   1
`define ST_LAYOUT_BIT    2

// ----------------------------------------
// reset values and layout constants
// ----------------------------------------
`define LINK_TO_RST      24'hFF_FFFF
`define RESP_TO_RST      24'hFF_FFFF
`define XF_SPACE_LO      17'h0_0100
`define XF_SPACE_HI      17'h0_FFFF
`define SER_BLK_SIZE     17'h0_0100
`define LANE_BLK_SIZE    17'h0_0400
`define USER_BLK_ALIGN   17'h0_0100

// ----------------------------------------
// timing: full-scale link timeout
// ----------------------------------------
`define CLK_MHZ          100
`define LINK_TO_MAX_MS   4500
`define LINK_TO_FULL     16777215
`define LINK_TO_UNIT_CYC ((`LINK_TO_MAX_MS * 1000 * `CLK_MHZ) / `LINK_TO_FULL)

`endif

// file: hdl/ep_cfg_pkg.sv
package ep_cfg_pkg;

  // advertised processing element kind
  typedef enum logic [1:0] {
    PE_BRIDGE,
    PE_MEMORY,
    PE_PROCESSOR
  } pe_type_t;

  // link timeout timer state
  typedef enum logic {
    TMR_IDLE,
    TMR_RUN
  } tmr_state_t;

endpackage

// file: hdl/link_timeout_timer.sv
`timescale 1ns/100ps
`include "ep_cfg_regs.svh"

module link_timeout_timer
  import ep_cfg_pkg::*;
#(
  parameter int UNIT_CYC = `LINK_TO_UNIT_CYC
) (
  input  wire logic        ref_clk,   // system clock
  input  wire logic        rst_b,     // async reset, low
  input  wire logic        ce,        // clock enable
  input  wire logic        start,     // symbol now awaited
  input  wire logic        done,      // awaited symbol arrived
  input  wire logic [23:0] limit,     // programmed timeout
  output logic             expired,   // one-cycle expiry pulse
  output logic             running    // timer active
);

  localparam int PW = (UNIT_CYC > 1) ? $clog2(UNIT_CYC) : 1;
  localparam logic [PW-1:0] PMAX = PW'(UNIT_CYC - 1);

  tmr_state_t  state_r;
  logic [PW-1:0] pre_r;
  logic [23:0] units_r;
  logic        tick;

  assign tick    = (pre_r == PMAX);
  assign running = (state_r == TMR_RUN);

  // -----------------------------
  // state and counters
  // -----------------------------
  // a new start always restarts, even mid-count
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= TMR_IDLE;
      pre_r   <= '0;
      units_r <= '0;
      expired <= 1'b0;
    end else if (ce) begin
      expired <= 1'b0;
      case (state_r)
        TMR_IDLE: begin
          if (start) begin                            // [RULE_17]
            state_r <= TMR_RUN;
            pre_r   <= '0;
            units_r <= '0;
          end
        end
        TMR_RUN: begin
          if (start) begin                            // [RULE_17]
            pre_r   <= '0;
            units_r <= '0;
          end else if (done) begin                    // [RULE_17]
            state_r <= TMR_IDLE;
          end else if (tick) begin
            pre_r <= '0;
            // duration grows linearly with limit [RULE_11]
            if (units_r >= limit) begin
              state_r <= TMR_IDLE;
              expired <= 1'b1;                        // [RULE_10]
            end else begin
              units_r <= units_r + 24'h00_0001;
            end
          end else begin
            pre_r <= pre_r + PW'(1);
          end
        end
        default: state_r <= TMR_IDLE;
      endcase
    end
  end

endmodule

// file: hdl/request_gate.sv
`timescale 1ns/100ps

module request_gate (
  input  wire logic master_en,  // issuing allowed
  input  wire logic ureq_valid, // user request offered
  output logic      ureq_ready, // user request taken
  output logic      lreq_valid, // request toward link
  input  wire logic lreq_ready  // link takes request
);

  // responses bypass this gate; only new requests are held
  assign lreq_valid = ureq_valid & master_en;  // [RULE_13]
  assign ureq_ready = lreq_ready & master_en;  // [RULE_13]

endmodule

// file: hdl/endpoint_config_registers.sv
// Operation
// RULE_01 - device identity register is fixed; writes are ignored.
// RULE_02 - assembly identity fields fixed at build time, no behavioural effect.
// RULE_03 - assembly revision fixed at build time, no behavioural effect.
// RULE_04 - element type is bridge, memory or processor; memory default; no effect.
// RULE_05 - serial port block spans 0x100 bytes, lane block 0x400 bytes.
// RULE_06 - serial port block base lies below lane block base.
// RULE_07 - each block base is a multiple of its own block size.
// RULE_08 - user block lives outside, above lane base plus 0x400.
// RULE_09 - user block base is 0x100 aligned inside extended space.
// RULE_10 - link timer runs while awaiting symbol; expiry starts error recovery.
// RULE_11 - link timeout scales linearly; all-ones gives about 4.5 s.
// RULE_12 - user logic does lost-packet detection from response timeout value.
// RULE_13 - without master enable no requests leave; responses still go.
// RULE_14 - cleared at build, requests stay refused until software writes 1.
// RULE_15 - host bit is recorded only and steers nothing.
// RULE_16 - discovered bit is recorded only and steers nothing.
// RULE_17 - link timer restarts per awaited symbol, stops on arrival.
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`include "ep_cfg_regs.svh"

module endpoint_config_registers
  import ep_cfg_pkg::*;
#(
  parameter logic [31:0] DEV_IDENT   = 32'h1234_5678, // arbitrary value
  parameter logic [15:0] ASM_ID      = 16'h00A5,      // arbitrary value
  parameter logic [15:0] ASM_VENDOR  = 16'h005A,      // arbitrary value
  parameter logic [15:0] ASM_REV     = 16'h0001,      // arbitrary value
  parameter pe_type_t    PE_TYPE     = PE_MEMORY,
  parameter logic [15:0] SER_BASE    = 16'h0100,
  parameter logic [15:0] LANE_BASE   = 16'h0400,
  parameter bit          USER_XF_EN  = 1'b0,
  parameter logic [15:0] USER_BASE   = 16'h0800,
  parameter logic [23:0] LINK_TO_RV  = `LINK_TO_RST,
  parameter logic [23:0] RESP_TO_RV  = `RESP_TO_RST,
  parameter bit          HOST_RV     = 1'b0,
  parameter bit          MEN_RV      = 1'b0,
  parameter bit          DISC_RV     = 1'b0,
  parameter int          UNIT_CYC    = `LINK_TO_UNIT_CYC
) (
  input  wire logic        ref_clk,        // 100 MHz clock
  input  wire logic        rst_b,          // async reset, low
  input  wire logic        ce,             // clock enable
  // wishbone slave
  input  wire logic        wb_cyc,         // bus cycle
  input  wire logic        wb_stb,         // strobe
  input  wire logic        wb_we,          // write
  input  wire logic [7:0]  wb_adr,         // byte address
  input  wire logic [3:0]  wb_sel,         // byte enables
  input  wire logic [31:0] wb_dat_w,       // write data
  output logic [31:0]      wb_dat_r,       // read data
  output logic             wb_ack,         // acknowledge
  // config space decode
  input  wire logic [15:0] xf_addr,        // config byte address
  output logic             xf_ser_sel,     // hits serial block
  output logic             xf_lane_sel,    // hits lane block
  output logic             xf_user_sel,    // hits user block
  // link timer
  input  wire logic        ack_wait,       // symbol now awaited
  input  wire logic        ack_seen,       // symbol arrived
  output logic             recovery_start, // start error recovery
  // request path
  input  wire logic        ureq_valid,     // user request
  output logic             ureq_ready,     // user request taken
  output logic             lreq_valid,     // request to link
  input  wire logic        lreq_ready,     // link takes request
  // loose outputs
  output logic [23:0]      resp_to_val,    // response timeout
  output logic             master_en,      // master enable level
  output logic             host_flag,      // host bit
  output logic             disc_flag       // discovered bit
);

  // ----------------------------------------
  // bus strobes
  // ----------------------------------------
  logic        ack_r;
  logic        req;
  logic        wr;
  logic [31:0] rd_nxt;
  logic [31:0] rd_r;

  assign req = wb_cyc & wb_stb & ~ack_r;
  assign wr  = req & wb_we;

  // byte-lane merge for writable registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // extended feature layout
  // ----------------------------------------
  logic [16:0] ser_b;
  logic [16:0] lane_b;
  logic [16:0] user_b;
  logic        layout_ok;
  logic        user_ok;

  assign ser_b  = {1'b0, SER_BASE};
  assign lane_b = {1'b0, LANE_BASE};
  assign user_b = {1'b0, USER_BASE};

  // optional outer block checked only when present
  assign user_ok = !USER_XF_EN ||
                   ((user_b >= lane_b + `LANE_BLK_SIZE) &&       // [RULE_08]
                    ((user_b % `USER_BLK_ALIGN) == 17'h0_0000) && // [RULE_09]
                    (user_b <= `XF_SPACE_HI));                   // [RULE_09]

  // a bad layout cannot be repaired here; it is flagged in status
  assign layout_ok = ((ser_b % `SER_BLK_SIZE) == 17'h0_0000) &&  // [RULE_07]
                     ((lane_b % `LANE_BLK_SIZE) == 17'h0_0000) && // [RULE_07]
                     (ser_b < lane_b) &&                         // [RULE_06]
                     (ser_b >= `XF_SPACE_LO) &&
                     (lane_b + `LANE_BLK_SIZE <= `XF_SPACE_HI + 17'h0_0001) &&
                     user_ok;

  // ----------------------------------------
  // block decode of config addresses
  // ----------------------------------------
  logic [16:0] ea;

  assign ea = {1'b0, xf_addr};

  // registered so fabric timing sees a flop
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      xf_ser_sel  <= 1'b0;
      xf_lane_sel <= 1'b0;
      xf_user_sel <= 1'b0;
    end else if (ce) begin
      xf_ser_sel  <= (ea >= ser_b) && (ea < ser_b + `SER_BLK_SIZE);   // [RULE_05]
      xf_lane_sel <= (ea >= lane_b) && (ea < lane_b + `LANE_BLK_SIZE); // [RULE_05]
      xf_user_sel <= USER_XF_EN && (ea >= user_b) &&
                     (ea <= `XF_SPACE_HI);                           // [RULE_08]
    end
  end

  // ----------------------------------------
  // fixed identity words
  // ----------------------------------------
  logic [31:0] asm_ident;
  logic [31:0] asm_info;
  logic [31:0] pe_feat;

  // build-time constants; only the read mux reads them
  assign asm_ident = {ASM_ID, ASM_VENDOR};              // [RULE_02]
  assign asm_info  = {ASM_REV, SER_BASE};               // [RULE_03]

  // one-hot type bit, memory unless built otherwise
  always_comb begin
    pe_feat = 32'h0000_0000;
    case (PE_TYPE)                                      // [RULE_04]
      PE_BRIDGE:    pe_feat[`PE_BRIDGE_BIT] = 1'b1;
      PE_PROCESSOR: pe_feat[`PE_PROC_BIT]   = 1'b1;
      default:      pe_feat[`PE_MEMORY_BIT] = 1'b1;
    endcase
  end

  // ----------------------------------------
  // link timeout register
  // ----------------------------------------
  logic [23:0] link_to_r;
  logic [31:0] link_to_w;

  assign link_to_w = merge({link_to_r, 8'h00}, wb_dat_w, wb_sel);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_to_r <= LINK_TO_RV;
    end else if (ce && wr && wb_adr == `OFS_LINK_TO) begin
      link_to_r <= link_to_w[31:`TO_VAL_LSB];
    end
  end

  // ----------------------------------------
  // response timeout register
  // ----------------------------------------
  logic [23:0] resp_to_r;
  logic [31:0] resp_to_w;

  assign resp_to_w = merge({resp_to_r, 8'h00}, wb_dat_w, wb_sel);

  // only stored and handed out; user logic does the timing
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_to_r <= RESP_TO_RV;
    end else if (ce && wr && wb_adr == `OFS_RESP_TO) begin
      resp_to_r <= resp_to_w[31:`TO_VAL_LSB];           // [RULE_12]
    end
  end

  assign resp_to_val = resp_to_r;                       // [RULE_12]

  // ----------------------------------------
  // port general control
  // ----------------------------------------
  logic        host_r;
  logic        men_r;
  logic        disc_r;
  logic [31:0] gc_cur;
  logic [31:0] gc_w;

  assign gc_cur = {host_r, men_r, disc_r, 29'h0000_0000};
  assign gc_w   = merge(gc_cur, wb_dat_w, wb_sel);

  // master enable starts at its build value [RULE_14]
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_r <= HOST_RV;
      men_r  <= MEN_RV;                                 // [RULE_14]
      disc_r <= DISC_RV;
    end else if (ce && wr && wb_adr == `OFS_GEN_CTRL) begin
      host_r <= gc_w[`GC_HOST_BIT];                     // [RULE_15]
      men_r  <= gc_w[`GC_MEN_BIT];                      // [RULE_14]
      disc_r <= gc_w[`GC_DISC_BIT];                     // [RULE_16]
    end
  end

  // host and discovered only reach status pins and the read mux
  assign host_flag = host_r;                            // [RULE_15]
  assign disc_flag = disc_r;                            // [RULE_16]
  assign master_en = men_r;

  // ----------------------------------------
  // request gating
  // ----------------------------------------
  request_gate u_gate (
    .master_en  (men_r),
    .ureq_valid (ureq_valid),
    .ureq_ready (ureq_ready),
    .lreq_valid (lreq_valid),
    .lreq_ready (lreq_ready)
  );

  // ----------------------------------------
  // link timeout timer
  // ----------------------------------------
  logic tmr_exp;
  logic tmr_run;

  link_timeout_timer #(
    .UNIT_CYC (UNIT_CYC)
  ) u_tmr (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .start   (ack_wait),
    .done    (ack_seen),
    .limit   (link_to_r),
    .expired (tmr_exp),
    .running (tmr_run)
  );

  assign recovery_start = tmr_exp;                      // [RULE_10]

  // ----------------------------------------
  // status: sticky expiry
  // ----------------------------------------
  logic exp_r;
  logic exp_clr;

  assign exp_clr = wr && wb_adr == `OFS_STATUS &&
                   wb_sel[0] && wb_dat_w[`ST_EXPIRED_BIT];

  // a new expiry beats a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      exp_r <= 1'b0;
    end else if (ce) begin
      if (tmr_exp) begin
        exp_r <= 1'b1;
      end else if (exp_clr) begin
        exp_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // identity word has no write path at all [RULE_01]
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (wb_adr == `OFS_DEV_IDENT) begin
      rd_nxt = DEV_IDENT;                               // [RULE_01]
    end else if (wb_adr == `OFS_ASM_IDENT) begin
      rd_nxt = asm_ident;
    end else if (wb_adr == `OFS_ASM_INFO) begin
      rd_nxt = asm_info;
    end else if (wb_adr == `OFS_PE_FEAT) begin
      rd_nxt = pe_feat;
    end else if (wb_adr == `OFS_SER_BASE) begin
      rd_nxt = {16'h0000, SER_BASE};
    end else if (wb_adr == `OFS_LANE_BASE) begin
      rd_nxt = {16'h0000, LANE_BASE};
    end else if (wb_adr == `OFS_USER_BASE) begin
      rd_nxt = USER_XF_EN ? {16'h0000, USER_BASE} : 32'h0000_0000;
    end else if (wb_adr == `OFS_LINK_TO) begin
      rd_nxt = {link_to_r, 8'h00};
    end else if (wb_adr == `OFS_RESP_TO) begin
      rd_nxt = {resp_to_r, 8'h00};
    end else if (wb_adr == `OFS_GEN_CTRL) begin
      rd_nxt = gc_cur;
    end else if (wb_adr == `OFS_STATUS) begin
      rd_nxt[`ST_EXPIRED_BIT] = exp_r;
      rd_nxt[`ST_RUNNING_BIT] = tmr_run;
      rd_nxt[`ST_LAYOUT_BIT]  = layout_ok;
    end
  end

  // ----------------------------------------
  // ack and read data
  // ----------------------------------------
  // unmapped words still ack, reading zero, so the bus never hangs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      rd_r  <= 32'h0000_0000;
    end else if (ce) begin
      ack_r <= req;
      if (req && !wb_we) begin
        rd_r <= rd_nxt;
      end
    end
  end

  assign wb_ack   = ack_r;
  assign wb_dat_r = rd_r;

endmodule

// file: verif/endpoint_config_checker_props.sv
`timescale 1ns/100ps
`include "ep_cfg_regs.svh"

module endpoint_config_checker #(
  parameter logic [15:0] SER_BASE  = 16'h0100,
  parameter logic [15:0] LANE_BASE = 16'h0400
) (
  input wire logic        ref_clk,        // clock
  input wire logic        rst_b,          // async reset, low
  input wire logic        ce,             // clock enable
  input wire logic        wb_cyc,         // bus cycle
  input wire logic        wb_stb,         // strobe
  input wire logic        wb_we,          // write
  input wire logic [7:0]  wb_adr,         // byte address
  input wire logic [3:0]  wb_sel,         // byte enables
  input wire logic [31:0] wb_dat_w,       // write data
  input wire logic        wb_ack,         // acknowledge
  input wire logic [15:0] xf_addr,        // decode address
  input wire logic        xf_ser_sel,     // serial block hit
  input wire logic        xf_lane_sel,    // lane block hit
  input wire logic        ack_wait,       // symbol awaited
  input wire logic        ack_seen,       // symbol arrived
  input wire logic        recovery_start, // timer expiry
  input wire logic        ureq_valid,     // user request
  input wire logic        ureq_ready,     // user request taken
  input wire logic        lreq_valid,     // request to link
  input wire logic        lreq_ready,     // link ready
  input wire logic        master_en       // master enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  // a request the slave takes at this edge
  sequence wb_req;
    wb_cyc && wb_stb && !wb_ack && ce;
  endsequence
  // timer stopped, then four cycles with no new wait
  sequence stopped_quiet;
    (ack_seen && !ack_wait) ##1 (!ack_wait)[*4];
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  ack_follows_a: assert property (wb_req |=> wb_ack)
    else $error("no ack after a taken request");
  ack_single_a: assert property (wb_ack && ce |=> !wb_ack)
    else $error("ack held past one cycle");
  gate_valid_a: assert property (lreq_valid == (ureq_valid && master_en))
    else $error("valid not gated by master enable");
  gate_ready_a: assert property (ureq_ready == (lreq_ready && master_en))
    else $error("ready not gated by master enable");
  men_by_write_a: assert property ($rose(master_en) |->
    $past(wb_cyc && wb_stb && ce && wb_we && wb_sel[3] && wb_dat_w[`GC_MEN_BIT]
          && wb_adr == `OFS_GEN_CTRL))
    else $error("master enable rose without a write");
  expiry_pulse_a: assert property (recovery_start |=> !recovery_start)
    else $error("recovery start wider than one cycle");
  stop_quiet_a: assert property (stopped_quiet |-> !recovery_start)
    else $error("expiry after symbol arrived");
  ser_decode_a: assert property ($past(rst_b) |-> xf_ser_sel ==
    ($past(xf_addr) >= SER_BASE && $past(xf_addr) < SER_BASE + 17'h0_0100))
    else $error("serial block decode wrong");
  lane_decode_a: assert property ($past(rst_b) |-> xf_lane_sel ==
    ($past(xf_addr) >= LANE_BASE && $past(xf_addr) < LANE_BASE + 17'h0_0400))
    else $error("lane block decode wrong");
endmodule

bind endpoint_config_registers endpoint_config_checker #(
  .SER_BASE(SER_BASE), .LANE_BASE(LANE_BASE)
) u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
  .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
  .wb_ack(wb_ack), .xf_addr(xf_addr), .xf_ser_sel(xf_ser_sel),
  .xf_lane_sel(xf_lane_sel), .ack_wait(ack_wait), .ack_seen(ack_seen),
  .recovery_start(recovery_start), .ureq_valid(ureq_valid),
  .ureq_ready(ureq_ready), .lreq_valid(lreq_valid),
  .lreq_ready(lreq_ready), .master_en(master_en)
);

// file: verif/endpoint_config_registers_bench.sv
`timescale 1ns/100ps

module endpoint_config_registers_bench;
  import ep_cfg_pkg::*;
  localparam int UNIT = 2; // short timer unit keeps the run brief

  logic        ref_clk = 0, rst_b = 0, ce = 1;
  logic        wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0000_0000, wb_dat_r, rd;
  logic [15:0] xf_addr = 16'h0000, r = 16'hC478;
  logic        xf_ser_sel, xf_lane_sel, xf_user_sel, recovery_start;
  logic        ack_wait = 0, ack_seen = 0, ureq_valid = 0, lreq_ready = 0;
  logic        ureq_ready, lreq_valid, master_en, host_flag, disc_flag;
  logic [23:0] resp_to_val, rv24;
  int          miscompares = 0, check_count = 0, n0, n1, n3, hits;

  endpoint_config_registers #(.UNIT_CYC(UNIT)) u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .xf_addr(xf_addr),
    .xf_ser_sel(xf_ser_sel), .xf_lane_sel(xf_lane_sel), .xf_user_sel(xf_user_sel),
    .ack_wait(ack_wait), .ack_seen(ack_seen), .recovery_start(recovery_start),
    .ureq_valid(ureq_valid), .ureq_ready(ureq_ready),
    .lreq_valid(lreq_valid), .lreq_ready(lreq_ready),
    .resp_to_val(resp_to_val), .master_en(master_en), .host_flag(host_flag),
    .disc_flag(disc_flag)
  );

  always #5 ref_clk = ~ref_clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return (s >> 1) ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction
  function automatic logic ser_hit(logic [15:0] a);
    return a >= 16'h0100 && a < 16'h0200;
  endfunction
  function automatic logic lane_hit(logic [15:0] a);
    return a >= 16'h0400 && a < 16'h0800;
  endfunction

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp_word(logic [31:0] g, logic [31:0] e, string m);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic cmp_bit(logic g, logic e, string m);
    cmp_word({31'h0, g}, {31'h0, e}, m);
  endtask
  task automatic cmp_int(int g, int e, string m);
    check_count++;
    if (g != e) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %0d exp %0d", $time, m, g, e);
    end
  endtask

  // one classic cycle; waits for ack under a bound
  task automatic wb(logic we, logic [7:0] a, logic [3:0] s, logic [31:0] d,
                    output logic [31:0] q);
    int k;
    @(posedge ref_clk);
    wb_cyc <= 1; wb_stb <= 1; wb_we <= we; wb_adr <= a; wb_sel <= s; wb_dat_w <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      if (wb_ack === 1'b1) break;
    end
    q = wb_dat_r;
    wb_cyc <= 0; wb_stb <= 0;
    if (k == 20) begin
      miscompares++;
      conclude();
    end
  endtask

  // optional early wait; count edges from last wait to expiry
  task automatic run_timer(logic [23:0] lim, logic pre, output int n);
    wb(1, 8'h20, 4'hF, {lim, 8'h00}, rd);
    if (pre) begin
      @(posedge ref_clk) ack_wait <= 1;
      @(posedge ref_clk) ack_wait <= 0;
      repeat (3) @(posedge ref_clk);
    end
    @(posedge ref_clk) ack_wait <= 1;
    @(posedge ref_clk) ack_wait <= 0;
    n = 1;
    while (recovery_start !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 300) begin
      miscompares++;
      conclude();
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  logic [31:0] rv  [12] = '{32'h1234_5678, 32'h0, 32'h00A5_005A, 32'h0001_0100,
                            32'h4000_0000, 32'h0000_0100, 32'h0000_0400, 32'h0,
                            32'hFFFF_FF00, 32'hFFFF_FF00, 32'h0, 32'h0000_0004};
  logic [31:0] gcw [4]  = '{32'h8000_0000, 32'h2000_0000, 32'h4000_0000, 32'h0};
  logic [15:0] edg [8]  = '{16'h00FF, 16'h0100, 16'h01FF, 16'h0200,
                            16'h03FF, 16'h0400, 16'h07FF, 16'h0800};
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1;
    // reset values; writes to fixed words must not stick
    for (int i = 0; i < 12; i++) begin
      wb(0, 8'(i * 4), 4'hF, 32'h0, rd);
      cmp_word(rd, rv[i], "reset value");
      if (i < 8) begin
        r = lfsr(r);
        wb(1, 8'(i * 4), 4'hF, {r, ~r}, rd);
        wb(0, 8'(i * 4), 4'hF, 32'h0, rd);
        cmp_word(rd, rv[i], "read-only kept");
      end
    end
    // control bits; requests gated until master enable set
    for (int i = 0; i < 4; i++) begin
      wb(1, 8'h28, 4'hF, gcw[i], rd);
      cmp_bit(host_flag, gcw[i][31], "host flag");
      cmp_bit(disc_flag, gcw[i][29], "discovered flag");
      cmp_bit(master_en, gcw[i][30], "master enable");
      repeat (4) begin
        r = lfsr(r);
        @(posedge ref_clk);
        ureq_valid <= r[0];
        lreq_ready <= r[1];
        #1 cmp_bit(lreq_valid, r[0] & gcw[i][30], "gated valid");
        cmp_bit(ureq_ready, r[1] & gcw[i][30], "gated ready");
      end
    end
    // response timeout value and byte-lane merge
    r = lfsr(r);
    rv24 = {r[7:0], lfsr(r)};
    wb(1, 8'h24, 4'hF, {rv24, 8'h00}, rd);
    cmp_word({8'h0, resp_to_val}, {8'h0, rv24}, "response timeout");
    wb(1, 8'h24, 4'b0010, 32'hFFFF_FFFF, rd);
    cmp_word({8'h0, resp_to_val}, {8'h0, rv24[23:8], 8'hFF}, "byte merge");
    // expiry time grows by one unit per count
    run_timer(24'd0, 0, n0);
    run_timer(24'd1, 0, n1);
    run_timer(24'd3, 0, n3);
    cmp_int(n1 - n0, UNIT, "timeout step");
    cmp_int(n3 - n0, 3 * UNIT, "timeout scale");
    wb(0, 8'h2C, 4'hF, 32'h0, rd);
    cmp_bit(rd[0], 1'b1, "expired sticky");
    wb(1, 8'h2C, 4'h1, 32'h0000_0001, rd);
    wb(0, 8'h2C, 4'hF, 32'h0, rd);
    cmp_word(rd, 32'h0000_0004, "expired cleared");
    // a fresh wait restarts the count
    run_timer(24'd3, 1, n1);
    cmp_int(n1, n3, "restart");
    // arrival of the symbol stops the timer
    @(posedge ref_clk) ack_wait <= 1;
    @(posedge ref_clk) ack_wait <= 0;
    @(posedge ref_clk) ack_seen <= 1;
    @(posedge ref_clk) ack_seen <= 0;
    hits = 0;
    repeat (40) @(posedge ref_clk) hits += (recovery_start === 1'b1);
    cmp_int(hits, 0, "stopped timer");
    // block decode: corners then random addresses
    for (int i = 0; i < 40; i++) begin
      r = lfsr(r);
      @(posedge ref_clk) xf_addr <= (i < 8) ? edg[i] : {4'h0, r[11:0]};
      @(posedge ref_clk);
      #1 cmp_bit(xf_ser_sel, ser_hit(xf_addr), "serial decode");
      cmp_bit(xf_lane_sel, lane_hit(xf_addr), "lane decode");
      cmp_bit(xf_user_sel, 1'b0, "user decode off");
    end
    conclude();
  end
endmodule
